//--- dcr_pkg.sv
// shared constants for the synthesizer control register bank
package dcr_pkg;
    localparam int          ADDR_W        = 5;
    localparam int          INSTR_BITS    = 8;
    localparam int          CTRL1_BITS    = 32;
    localparam int          FRAME_BITS    = INSTR_BITS + CTRL1_BITS;
    localparam int          CNT_W         = 6;
    localparam int          RW_BIT        = 7;
    localparam logic [ADDR_W-1:0] ADDR_CTRL1  = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_UNUSED = 5'h05;
    localparam logic [ADDR_W-1:0] ADDR_LAST   = 5'h10;
    localparam logic [31:0] CTRL1_RESET   = 32'h0000_0000;
    localparam int          B_MODULUS     = 28;
    localparam int          B_INT_PROFILE = 27;
    localparam int          B_NO_MATCH    = 26;
    localparam int          B_LSB_FIRST   = 23;
    localparam int          B_PROF_HI     = 22;
    localparam int          B_PROF_LO     = 20;
    localparam int          B_SYNC_OFF    = 19;
    localparam int          B_DIRECT_SW   = 16;
    localparam int          B_CLR_AUX     = 15;
    localparam int          B_CLR_PHASE   = 14;
    localparam int          PROF_W        = 3;
    localparam int          SYNC_DIV_DEF  = 4;
endpackage

//--- dcr_pin_sync.sv
// two-flop synchroniser bank with rise and fall detection
`timescale 1ns/1ps
module dcr_pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] prev_reg;

    if (WIDTH < 1) begin : g_width_check
        $error("dcr_pin_sync: WIDTH must be at least 1");
    end

    // meta_reg feeds sync_reg only
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end else begin
            meta_reg <= pin;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign rise  = sync_reg & ~prev_reg;
    assign fall  = ~sync_reg & prev_reg;
endmodule

//--- dcr_ctrl_bank.sv
// serial-programmed control register bank, control word one (fields in bits 28 down to 14)
`timescale 1ns/1ps
module dcr_ctrl_bank
    import dcr_pkg::*;
#(
    parameter int SYNC_DIV = dcr_pkg::SYNC_DIV_DEF
) (
    input  wire logic                      MCLK,
    input  wire logic                      RST,
    input  wire logic                      SCLK,
    input  wire logic                      CS_N,
    input  wire logic                      SDIO_IN,
    output logic                           SDIO_OUT,
    output logic                           SDIO_OE,
    input  wire logic                      IO_UPDATE,
    input  wire logic [dcr_pkg::PROF_W-1:0] PROFILE_PINS,
    input  wire logic                      SWEEP_ENABLE,
    output logic                           SYNC_CLK,
    output logic                           SYNC_CLK_OE,
    output logic [dcr_pkg::PROF_W-1:0]     PROFILE_SEL,
    output logic                           AUX_SWEEP_MODE,
    output logic                           AUX_MODULUS_MODE,
    output logic                           PIPE_MATCH,
    output logic                           LSB_FIRST,
    output logic                           DIRECT_SWITCH,
    output logic                           AUX_ACC_CLEAR,
    output logic                           PHASE_ACC_CLEAR,
    output logic [31:0]                    CTRL1_ACTIVE
);
    import dcr_pkg::*;

    if (SYNC_DIV < 2) begin : g_div_check
        $error("dcr_ctrl_bank: SYNC_DIV must be at least 2");
    end

    localparam int DIV_W = $clog2(SYNC_DIV);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SYNC_DIV - 1);
    localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(SYNC_DIV / 2);
    localparam logic [CNT_W-1:0] CNT_INSTR = CNT_W'(INSTR_BITS);
    localparam logic [CNT_W-1:0] CNT_INSTR_LAST = CNT_W'(INSTR_BITS - 1);
    localparam logic [CNT_W-1:0] CNT_FRAME = CNT_W'(FRAME_BITS);
    localparam logic [CNT_W-1:0] CNT_FRAME_LAST = CNT_W'(FRAME_BITS - 1);

    logic                  sclk_rise;
    logic                  sclk_fall;
    logic                  sdio_lvl;
    logic                  upd_rise;
    logic [PROF_W-1:0]     prof_lvl;
    logic [2:0]            ctl_lvl;
    logic [2:0]            ctl_rise;
    logic [2:0]            ctl_fall;

    logic [CNT_W-1:0]      bit_cnt_reg;
    logic [INSTR_BITS-1:0] instr_reg;
    logic [INSTR_BITS-1:0] instr_next;
    logic [CTRL1_BITS-1:0] shift_reg;
    logic [CTRL1_BITS-1:0] shift_next;
    logic [CTRL1_BITS-1:0] buf_reg;
    logic [CTRL1_BITS-1:0] act_reg;
    logic [CTRL1_BITS-1:0] rd_word_reg;
    logic                  sdio_out_reg;
    logic                  sdio_oe_reg;
    logic                  upd_pend_reg;
    logic                  prof_pend_reg;
    logic [PROF_W-1:0]     prof_prev_reg;
    logic [DIV_W-1:0]      div_reg;
    logic                  sync_clk_reg;
    logic                  sync_edge;
    logic                  lsb_first;
    logic                  cs_active;
    logic                  instr_done;
    logic                  is_read;
    logic [ADDR_W-1:0]     addr;
    logic [ADDR_W-1:0]     addr_next;
    logic                  addr_mapped;
    logic [CNT_W-1:0]      data_idx;
    logic [PROF_W-1:0]     prof_eff;

    // pins come from the host's domain, so every pin except SWEEP_ENABLE is resynchronised
    dcr_pin_sync #(.WIDTH(3)) u_ctl_sync (
        .clk   (MCLK),
        .rst   (RST),
        // select enters inverted so its reset value equals the idle pin
        .pin   ({IO_UPDATE, SCLK, ~CS_N}),
        .level (ctl_lvl),
        .rise  (ctl_rise),
        .fall  (ctl_fall)
    );

    dcr_pin_sync #(.WIDTH(PROF_W + 1)) u_dat_sync (
        .clk   (MCLK),
        .rst   (RST),
        .pin   ({PROFILE_PINS, SDIO_IN}),
        .level ({prof_lvl, sdio_lvl}),
        .rise  (),
        .fall  ()
    );

    assign cs_active = ctl_lvl[0];
    assign sclk_rise = ctl_rise[1];
    assign sclk_fall = ctl_fall[1];
    assign upd_rise  = ctl_rise[2];

    // order bit acts straight from the buffer so the next frame already uses it
    // serial bit order
    assign lsb_first = buf_reg[B_LSB_FIRST];

    assign instr_done = cs_active && (bit_cnt_reg >= CNT_INSTR);
    assign is_read    = instr_reg[RW_BIT];
    assign addr       = instr_reg[ADDR_W-1:0];
    // decode from the instruction as it completes on the eighth bit
    assign addr_next   = instr_next[ADDR_W-1:0];
    assign addr_mapped = (addr_next <= ADDR_LAST) && (addr_next != ADDR_UNUSED);
    assign data_idx    = bit_cnt_reg - CNT_INSTR;

    always_comb begin
        instr_next = lsb_first ? {sdio_lvl, instr_reg[INSTR_BITS-1:1]}
                               : {instr_reg[INSTR_BITS-2:0], sdio_lvl};
        shift_next = lsb_first ? {sdio_lvl, shift_reg[CTRL1_BITS-1:1]}
                               : {shift_reg[CTRL1_BITS-2:0], sdio_lvl};
    end

    always_ff @(posedge MCLK) begin
        if (RST || !cs_active) begin
            bit_cnt_reg <= '0;
        end else if (sclk_rise && bit_cnt_reg != CNT_FRAME) begin
            bit_cnt_reg <= bit_cnt_reg + CNT_W'(1);
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            instr_reg <= '0;
            shift_reg <= '0;
        end else if (cs_active && sclk_rise) begin
            if (bit_cnt_reg < CNT_INSTR) begin
                instr_reg <= instr_next;
            end else if (bit_cnt_reg < CNT_FRAME) begin
                shift_reg <= shift_next;
            end
        end
    end

    // other mapped addresses live elsewhere; their bytes are ignored here
    // buffered write
    always_ff @(posedge MCLK) begin
        if (RST) begin
            buf_reg <= CTRL1_RESET;
        end else if (cs_active && sclk_rise && bit_cnt_reg == CNT_FRAME_LAST
                     && !is_read && addr == ADDR_CTRL1) begin
            buf_reg <= shift_next;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            rd_word_reg <= '0;
        end else if (cs_active && sclk_rise && bit_cnt_reg == CNT_INSTR_LAST) begin
            rd_word_reg <= (addr_mapped && addr_next == ADDR_CTRL1)
                           ? buf_reg : '0;
        end
    end

    // read data change on the falling edge, host samples on the rising one
    always_ff @(posedge MCLK) begin
        if (RST || !cs_active) begin
            sdio_out_reg <= 1'b0;
            sdio_oe_reg  <= 1'b0;
        end else if (sclk_fall && instr_done && is_read) begin
            if (bit_cnt_reg < CNT_FRAME) begin
                sdio_out_reg <= lsb_first ? rd_word_reg[data_idx[4:0]]
                                          : rd_word_reg[~data_idx[4:0]];
                sdio_oe_reg  <= 1'b1;
            end else begin
                sdio_oe_reg  <= 1'b0;
            end
        end
    end

    // sync clock divider; sync_edge marks its rising edge
    always_ff @(posedge MCLK) begin
        if (RST) begin
            div_reg <= '0;
        end else if (div_reg == DIV_LAST) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + DIV_W'(1);
        end
    end

    assign sync_edge = (div_reg == DIV_LAST);

    always_ff @(posedge MCLK) begin
        if (RST) begin
            sync_clk_reg <= 1'b0;
        end else begin
            sync_clk_reg <= !act_reg[B_SYNC_OFF] && (sync_edge || div_reg < DIV_HALF - DIV_W'(1));
        end
    end

    assign prof_eff = act_reg[B_INT_PROFILE] ? act_reg[B_PROF_HI:B_PROF_LO] : prof_lvl;

    // a new strobe in the taking cycle stays pending
    always_ff @(posedge MCLK) begin
        if (RST) begin
            upd_pend_reg  <= 1'b0;
            prof_pend_reg <= 1'b0;
            prof_prev_reg <= '0;
        end else begin
            prof_prev_reg <= prof_eff;
            upd_pend_reg  <= upd_rise || (upd_pend_reg && !sync_edge);
            prof_pend_reg <= (prof_eff != prof_prev_reg) || (prof_pend_reg && !sync_edge);
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            act_reg <= CTRL1_RESET;
        end else if (sync_edge && upd_pend_reg) begin
            act_reg <= buf_reg;
        end else if (sync_edge && prof_pend_reg) begin
            act_reg[B_CLR_AUX] <= buf_reg[B_CLR_AUX];
        end
    end

    assign SDIO_OUT    = sdio_out_reg;
    assign SDIO_OE     = sdio_oe_reg;
    assign SYNC_CLK    = sync_clk_reg;
    assign SYNC_CLK_OE = !act_reg[B_SYNC_OFF];
    assign PROFILE_SEL = prof_eff;
    assign AUX_MODULUS_MODE = SWEEP_ENABLE && act_reg[B_MODULUS];
    assign AUX_SWEEP_MODE   = SWEEP_ENABLE && !act_reg[B_MODULUS];
    assign PIPE_MATCH      = !act_reg[B_NO_MATCH];
    assign LSB_FIRST       = lsb_first;
    assign DIRECT_SWITCH   = act_reg[B_DIRECT_SW];
    assign AUX_ACC_CLEAR   = act_reg[B_CLR_AUX];
    assign PHASE_ACC_CLEAR = act_reg[B_CLR_PHASE];
    assign CTRL1_ACTIVE    = act_reg;
endmodule

//--- dcr_ctrl_bank_checker.sv
// port assertions for the control register bank
`timescale 1ns/1ps
module dcr_ctrl_bank_checker
    import dcr_pkg::*;
#(
    parameter int SYNC_DIV = dcr_pkg::SYNC_DIV_DEF
) (
    input wire logic                       MCLK,
    input wire logic                       RST,
    input wire logic                       CS_N,
    input wire logic                       SDIO_OE,
    input wire logic                       IO_UPDATE,
    input wire logic                       SWEEP_ENABLE,
    input wire logic                       SYNC_CLK,
    input wire logic                       SYNC_CLK_OE,
    input wire logic [dcr_pkg::PROF_W-1:0] PROFILE_SEL,
    input wire logic                       AUX_SWEEP_MODE,
    input wire logic                       AUX_MODULUS_MODE,
    input wire logic                       PIPE_MATCH,
    input wire logic                       DIRECT_SWITCH,
    input wire logic                       AUX_ACC_CLEAR,
    input wire logic                       PHASE_ACC_CLEAR,
    input wire logic [31:0]                CTRL1_ACTIVE
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    localparam int UPD_MAX = SYNC_DIV + 5;
    logic [3:0] age_reg;
    // cycles since the update strobe was last high, saturating
    always_ff @(posedge MCLK) begin
        if (RST || IO_UPDATE) age_reg <= 4'h0;
        else if (age_reg != 4'hf) age_reg <= age_reg + 4'h1;
    end
    // aux clear bit excluded: a profile change may also move it
    a_active_update: assert property (
        (CTRL1_ACTIVE & ~32'h0000_8000) != ($past(CTRL1_ACTIVE) & ~32'h0000_8000)
        |-> age_reg <= UPD_MAX) else $error("active word moved without update");
    a_sync_oe: assert property (
        SYNC_CLK_OE != CTRL1_ACTIVE[19]) else $error("sync clock enable wrong");
    a_sync_static: assert property (
        CTRL1_ACTIVE[19] [*3] |-> !SYNC_CLK) else $error("sync clock not static");
    a_profile_sel: assert property (
        CTRL1_ACTIVE[27] |-> PROFILE_SEL == CTRL1_ACTIVE[22:20]) else $error("profile wrong");
    a_modulus_mode: assert property (
        AUX_MODULUS_MODE == (SWEEP_ENABLE && CTRL1_ACTIVE[28])) else $error("modulus wrong");
    a_sweep_mode: assert property (
        AUX_SWEEP_MODE == (SWEEP_ENABLE && !CTRL1_ACTIVE[28])) else $error("sweep wrong");
    a_pipe_match: assert property (
        PIPE_MATCH != CTRL1_ACTIVE[26]) else $error("pipe match wrong");
    a_mode_bits: assert property (
        {DIRECT_SWITCH, AUX_ACC_CLEAR, PHASE_ACC_CLEAR} == CTRL1_ACTIVE[16:14])
        else $error("mode bits wrong");
    // four sampled highs cover the select synchroniser and the output flop
    a_oe_idle: assert property (
        CS_N [*4] |-> !SDIO_OE) else $error("read driver left on");
endmodule
bind dcr_ctrl_bank dcr_ctrl_bank_checker #(.SYNC_DIV(SYNC_DIV)) u_chk (.MCLK, .RST,
    .CS_N, .SDIO_OE,
    .IO_UPDATE, .SWEEP_ENABLE, .SYNC_CLK, .SYNC_CLK_OE, .PROFILE_SEL, .AUX_SWEEP_MODE,
    .AUX_MODULUS_MODE, .PIPE_MATCH, .DIRECT_SWITCH, .AUX_ACC_CLEAR, .PHASE_ACC_CLEAR,
    .CTRL1_ACTIVE);

//--- dcr_host.sv
// host model driving the serial programming port
`timescale 1ns/1ps
module dcr_host (
    input  wire logic mclk,
    input  wire logic sdio_out,
    output logic      sclk,
    output logic      cs_n,
    output logic      sdio_in
);
    // half period well above the three-cycle input synchroniser
    localparam int HALF = 5;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdio_in = 1'b0;
    end
    task automatic half();
        repeat (HALF) @(posedge mclk);
        #1;
    endtask
    task automatic frame(input logic rd, input logic [4:0] addr, input logic [31:0] wd,
                         input logic lsb, output logic [31:0] rdat);
        logic [39:0] w;
        int          k;
        w = {rd, 2'b00, addr, wd};
        rdat = 32'h0;
        cs_n = 1'b0;
        for (int i = 0; i < 40; i++) begin
            k = lsb ? (i < 8 ? 32 + i : i - 8) : 39 - i;
            // released line shows no stale level
            sdio_in = (rd && i >= 8) ? ~sdio_in : w[k];
            half();
            if (i >= 8) rdat[k] = sdio_out;
            sclk = 1'b1;
            half();
            sclk = 1'b0;
        end
        half();
        cs_n = 1'b1;
        sdio_in = ~sdio_in;
        half();
    endtask
endmodule

//--- tb_dcr_ctrl_bank.sv
// self-checking bench for the control register bank
`timescale 1ns/1ps
module tb_dcr_ctrl_bank;
    import dcr_pkg::*;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        upd = 1'b0;
    logic        sweep = 1'b0;
    logic [2:0]  pins = 3'h0;
    logic        sclk, cs_n, sdi, sdo, sdo_oe, sync_clk, sync_oe, swp, modu;
    logic        pipe, lsb, dsw, aclr, pclr;
    logic [2:0]  psel;
    logic [31:0] act, rdat;
    int          err_count = 0;
    int          compares = 0;
    int          n;
    int          oe_cnt = 0;
    logic [4:0]  bad [3] = '{ADDR_UNUSED, 5'h11, 5'h01};
    // word, pins, sweep enable, expected profile, expected modulus
    logic [39:0] rows [4] = '{{32'h1c59_c000, 3'h2, 1'b1, 3'h5, 1'b1},
        {32'h0030_0000, 3'h6, 1'b1, 3'h6, 1'b0}, {32'h1870_4000, 3'h1, 1'b0, 3'h7, 1'b0},
        {32'h0000_0000, 3'h4, 1'b0, 3'h4, 1'b0}};
    always #2 mclk = ~mclk;
    dcr_ctrl_bank #(.SYNC_DIV(4)) dut (.MCLK(mclk), .RST(rst), .SCLK(sclk), .CS_N(cs_n),
        .SDIO_IN(sdi), .SDIO_OUT(sdo), .SDIO_OE(sdo_oe), .IO_UPDATE(upd), .PROFILE_PINS(pins),
        .SWEEP_ENABLE(sweep), .SYNC_CLK(sync_clk), .SYNC_CLK_OE(sync_oe), .PROFILE_SEL(psel),
        .AUX_SWEEP_MODE(swp), .AUX_MODULUS_MODE(modu), .PIPE_MATCH(pipe), .LSB_FIRST(lsb),
        .DIRECT_SWITCH(dsw), .AUX_ACC_CLEAR(aclr), .PHASE_ACC_CLEAR(pclr), .CTRL1_ACTIVE(act));
    dcr_host host (.mclk(mclk), .sdio_out(sdo), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdi));
    // cycles in which the device drives the read line
    always @(posedge mclk) begin
        if (sdo_oe) oe_cnt++;
    end
    // sync clock rises over 40 cycles: ten at a divide of four
    task automatic count_rises(output int cnt);
        logic prev;
        cnt = 0;
        prev = sync_clk;
        repeat (40) begin
            @(posedge mclk);
            #1;
            if (sync_clk && !prev) cnt++;
            prev = sync_clk;
        end
    endtask
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("err_count %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic do_reset();
        rst = 1'b1;
        repeat (10) @(posedge mclk);
        #1 rst = 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        chk({act, pipe, sync_oe}, {32'h0, 2'b11});
    endtask
    task automatic pulse_update();
        @(posedge mclk);
        #1 upd = 1'b1;
        repeat (2) @(posedge mclk);
        #1 upd = 1'b0;
        repeat (12) @(posedge mclk);
        #1;
    endtask
    initial begin
        #1;
        do_reset();
        for (int i = 0; i < 4; i++) begin
            pins = rows[i][7:5];
            sweep = rows[i][4];
            host.frame(1'b0, ADDR_CTRL1, rows[i][39:8], 1'b0, rdat);
            pulse_update();
            chk(act, rows[i][39:8]);
            chk({psel, modu, swp}, {rows[i][3:0], rows[i][4] & ~rows[i][36]});
            chk({pipe, sync_oe, dsw, aclr, pclr}, {~rows[i][34], ~rows[i][27], rows[i][24:22]});
            count_rises(n);
            chk(40'(n), rows[i][27] ? 40'h0 : 40'ha);
        end
        host.frame(1'b0, ADDR_CTRL1, 32'h0000_8000, 1'b0, rdat);
        oe_cnt = 0;
        host.frame(1'b1, ADDR_CTRL1, 32'h0, 1'b0, rdat);
        chk({rdat, aclr}, {32'h0000_8000, 1'b0});
        // 32 data bits of ten cycles each
        chk(40'(oe_cnt), 40'h140);
        pulse_update();
        chk(aclr, 1'b1);
        // effective profile moves while pins are the source
        host.frame(1'b0, ADDR_CTRL1, 32'h0000_4000, 1'b0, rdat);
        pins = 3'h3;
        repeat (16) @(posedge mclk);
        #1;
        chk({aclr, pclr}, 2'b00);
        foreach (bad[j]) begin
            host.frame(1'b0, bad[j], 32'hffff_ffff, 1'b0, rdat);
            host.frame(1'b1, bad[j], 32'h0, 1'b0, rdat);
            chk(rdat, 32'h0);
        end
        host.frame(1'b1, ADDR_CTRL1, 32'h0, 1'b0, rdat);
        chk(rdat, 32'h0000_4000);
        host.frame(1'b0, ADDR_CTRL1, 32'h0080_4000, 1'b0, rdat);
        chk(lsb, 1'b1);
        host.frame(1'b1, ADDR_CTRL1, 32'h0, 1'b1, rdat);
        chk(rdat, 32'h0080_4000);
        host.frame(1'b0, ADDR_CTRL1, 32'h0000_4000, 1'b1, rdat);
        host.frame(1'b1, ADDR_CTRL1, 32'h0, 1'b0, rdat);
        chk({rdat, lsb}, {32'h0000_4000, 1'b0});
        pulse_update();
        chk(pclr, 1'b1);
        do_reset();
        stop_test();
    end
    // whole run needs about 30 us
    initial begin
        #200000;
        err_count++;
        stop_test();
    end
endmodule
